/* File: core/flash_opt_pkg.sv */
package flash_opt_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_OPT = 8'h00;
   localparam logic [7:0] OFF_CFG = 8'h04;
   localparam logic [7:0] OFF_DIV = 8'h08;
   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int OPT_BACKDOOR_BIT = 7;
   localparam int OPT_NORED_BIT = 6;
   localparam int OPT_SEC_LSB = 0;
   localparam logic [7:0] OPT_IMPL_MASK = 8'hC3;
   localparam logic [7:0] OPT_RST = 8'h00;
   localparam int CFG_KEY_ACCESS_BIT = 5;
   localparam logic [7:0] CFG_MASK = 8'hE0;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam int DIV_LOADED_BIT = 7;
   localparam int DIV_PRESCALE_BIT = 6;
   localparam logic [7:0] DIV_RST = 8'h00;
   localparam logic [1:0] SEC_UNSECURED = 2'b10;
   localparam logic [15:0] KEY_BASE = 16'hFFB0;
   localparam logic [7:0] INVALID_READ = 8'hFF;
   localparam logic [2:0] PRE_LAST = 3'h7;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int PULSE_MIN_NS = 5000;
   localparam int PULSE_MAX_NS = 6700;
   localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam int PULSE_MAX_CYC = PULSE_MAX_NS / CLK_PERIOD_NS;
   // ----------------------------------------------------------------
   // Types and helpers
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_OPT = 2'b00,
      ST_KEY = 2'b01,
      ST_RUN = 2'b10
   } load_state_e;

   function automatic logic is_unsecured(input logic [1:0] code);
      return code == SEC_UNSECURED;
   endfunction : is_unsecured

   function automatic logic in_key_window(input logic [15:0] addr);
      return addr[15:3] == KEY_BASE[15:3];
   endfunction : in_key_window
endpackage : flash_opt_pkg

/* File: core/key_store.sv */
`timescale 1ns/100ps
`default_nettype none
module key_store #(
   parameter int W = 8,
   parameter int D = 8
) (
   // Clock
   input wire logic clock,
   // Write port
   input wire logic we,
   input wire logic [$clog2(D)-1:0] waddr,
   input wire logic [W-1:0] wdata,
   // Read port
   input wire logic [$clog2(D)-1:0] raddr,
   output logic [W-1:0] rdata
);
   // A single word would leave the address ports without a bit
   if (D < 2 || W < 1) begin : g_bad_size
      $error("key_store needs D of at least 2 and W of at least 1");
   end

   logic [W-1:0] mem [D];

   always_ff @(posedge clock) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule : key_store
`default_nettype wire

/* File: core/flash_option_security_config.sv */
`timescale 1ns/100ps
`default_nettype none
module flash_option_security_config
   import flash_opt_pkg::*;
#(
   parameter int KEY_BYTES = 8,
   parameter logic [15:0] NV_OPT_ADDR = 16'hFFBF
) (
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Nonvolatile load port to the array
   output logic nv_rd_req,
   output logic [15:0] nv_rd_addr,
   input wire logic [7:0] nv_rd_data,
   input wire logic nv_rd_valid,
   // CPU writes into flash space
   input wire logic fl_wr_valid,
   input wire logic [15:0] fl_wr_addr,
   input wire logic [7:0] fl_wr_data,
   input wire logic fl_wr_debug,
   // Flash command path
   output logic cmd_wr_valid,
   output logic [15:0] cmd_wr_addr,
   output logic [7:0] cmd_wr_data,
   // Flash array reads
   input wire logic [7:0] fl_rd_data,
   output logic [7:0] cpu_rd_data,
   // Blank check result
   input wire logic blank_check_pass,
   // Security and debug
   input wire logic debug_mem_req,
   output logic debug_mem_grant,
   output logic secure,
   output logic vector_redirect,
   // Flash clock
   output logic fclk_pulse
);
   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   // Key index and byte counter widths assume exactly eight key bytes
   if (KEY_BYTES != 8) begin : g_bad_key
      $error("KEY_BYTES must be 8");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   load_state_e state_r;
   logic [2:0] load_idx_r;
   logic [7:0] opt_r;
   logic [7:0] cfg_r;
   logic [7:0] div_r;
   logic pend_r;
   logic da_write_r;
   logic [7:0] da_addr_r;
   logic [3:0] key_cnt_r;
   logic key_miss_r;
   logic [7:0] key_rdata;
   logic [2:0] pre_cnt_r;
   logic [5:0] div_cnt_r;
   logic [7:0] rd_byte;
   logic opt_wr, cfg_wr, div_wr, key_clear_evt, key_wr, key_ok, key_unlock;
   logic blank_unlock, tick, run;

   assign run = state_r == ST_RUN;

   // ----------------------------------------------------------------
   // Nonvolatile load after reset
   // ----------------------------------------------------------------
   // Security reads as secure until the option byte has arrived
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_r <= ST_OPT;
         nv_rd_req <= 1'b1;
         nv_rd_addr <= NV_OPT_ADDR;
         load_idx_r <= 3'h0;
      end else begin
         case (state_r)
            ST_OPT: begin
               if (nv_rd_valid) begin
                  state_r <= ST_KEY;
                  nv_rd_addr <= KEY_BASE;
               end
            end
            ST_KEY: begin
               if (nv_rd_valid) begin
                  if (load_idx_r == 3'(KEY_BYTES - 1)) begin
                     state_r <= ST_RUN;
                     nv_rd_req <= 1'b0;
                  end else begin
                     load_idx_r <= load_idx_r + 3'h1;
                     nv_rd_addr <= nv_rd_addr + 16'h0001;
                  end
               end
            end
            ST_RUN: begin
            end
            default: begin
               state_r <= ST_OPT;
            end
         endcase
      end
   end

   key_store #(.W(8), .D(KEY_BYTES)) u_key (
      .clock(clock),
      .we(state_r == ST_KEY && nv_rd_valid),
      .waddr(load_idx_r),
      .wdata(nv_rd_data),
      .raddr(key_cnt_r[2:0]),
      .rdata(key_rdata)
   );

   // ----------------------------------------------------------------
   // Option shadow
   // ----------------------------------------------------------------
   assign blank_unlock = run && blank_check_pass;

   // No bus write path exists into this register
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         opt_r <= OPT_RST;
      end else if (state_r == ST_OPT && nv_rd_valid) begin
         opt_r <= nv_rd_data & OPT_IMPL_MASK;
      end else if (key_unlock || blank_unlock) begin
         opt_r[OPT_SEC_LSB +: 2] <= SEC_UNSECURED;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         secure <= 1'b1;
         vector_redirect <= 1'b0;
         debug_mem_grant <= 1'b0;
      end else begin
         secure <= !is_unsecured(opt_r[OPT_SEC_LSB +: 2]);
         vector_redirect <= !opt_r[OPT_NORED_BIT];
         debug_mem_grant <= debug_mem_req
                            && is_unsecured(opt_r[OPT_SEC_LSB +: 2]);
      end
   end

   // ----------------------------------------------------------------
   // AHB-Lite slave, one wait state on every transfer
   // ----------------------------------------------------------------
   // The wait state lets a read right after a write see the new value
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pend_r <= 1'b0;
         da_write_r <= 1'b0;
         da_addr_r <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
      end else if (pend_r) begin
         pend_r <= 1'b0;
         hreadyout <= 1'b1;
         if (!da_write_r) begin
            hrdata <= {24'h00_0000, rd_byte};
         end
      end else if (hsel && htrans[1] && hready) begin
         pend_r <= 1'b1;
         hreadyout <= 1'b0;
         da_write_r <= hwrite;
         da_addr_r <= haddr[7:0];
      end
   end

   always_comb begin
      case (da_addr_r)
         OFF_OPT: rd_byte = opt_r & OPT_IMPL_MASK;
         OFF_CFG: rd_byte = cfg_r & CFG_MASK;
         OFF_DIV: rd_byte = div_r;
         default: rd_byte = 8'h00;
      endcase
   end

   assign opt_wr = pend_r && da_write_r && da_addr_r == OFF_OPT;
   assign cfg_wr = pend_r && da_write_r && da_addr_r == OFF_CFG;
   assign div_wr = pend_r && da_write_r && da_addr_r == OFF_DIV;
   assign key_clear_evt = cfg_wr && cfg_r[CFG_KEY_ACCESS_BIT]
                          && !hwdata[CFG_KEY_ACCESS_BIT];

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cfg_r <= CFG_RST;
      end else if (cfg_wr) begin
         cfg_r <= hwdata[7:0] & CFG_MASK;
      end
   end

   // Divider settings take only the first write after reset
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         div_r <= DIV_RST;
      end else if (div_wr && !div_r[DIV_LOADED_BIT]) begin
         div_r <= {1'b1, hwdata[6:0]};
      end
   end

   // ----------------------------------------------------------------
   // Key comparator
   // ----------------------------------------------------------------
   // Stored byte for the next slot is read a cycle ahead; back to back
   // key writes would compare stale data and so simply fail the match
   assign key_wr = run && fl_wr_valid && !fl_wr_debug
                   && cfg_r[CFG_KEY_ACCESS_BIT] && in_key_window(fl_wr_addr);
   assign key_ok = fl_wr_addr[2:0] == key_cnt_r[2:0] && !key_cnt_r[3]
                   && fl_wr_data == key_rdata;
   assign key_unlock = key_clear_evt && key_cnt_r == 4'(KEY_BYTES)
                       && !key_miss_r && opt_r[OPT_BACKDOOR_BIT];

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         key_cnt_r <= 4'h0;
         key_miss_r <= 1'b0;
      end else if (key_clear_evt) begin
         key_cnt_r <= 4'h0;
         key_miss_r <= 1'b0;
      end else if (key_wr) begin
         if (!key_cnt_r[3]) begin
            key_cnt_r <= key_cnt_r + 4'h1;
         end
         if (!key_ok) begin
            key_miss_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Flash write routing and read gating
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cmd_wr_valid <= 1'b0;
         cmd_wr_addr <= 16'h0000;
         cmd_wr_data <= 8'h00;
         cpu_rd_data <= 8'h00;
      end else begin
         cmd_wr_valid <= fl_wr_valid && !(cfg_r[CFG_KEY_ACCESS_BIT]
                         && in_key_window(fl_wr_addr));
         cmd_wr_addr <= fl_wr_addr;
         cmd_wr_data <= fl_wr_data;
         cpu_rd_data <= cfg_r[CFG_KEY_ACCESS_BIT] ? INVALID_READ
                        : fl_rd_data;
      end
   end

   // ----------------------------------------------------------------
   // Flash clock divider
   // ----------------------------------------------------------------
   // Pulse period is (divisor+1) or 8*(divisor+1) bus cycles
   assign tick = !div_r[DIV_PRESCALE_BIT] || pre_cnt_r == PRE_LAST;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pre_cnt_r <= 3'h0;
         div_cnt_r <= 6'h00;
         fclk_pulse <= 1'b0;
      end else if (!div_r[DIV_LOADED_BIT]) begin
         pre_cnt_r <= 3'h0;
         div_cnt_r <= 6'h00;
         fclk_pulse <= 1'b0;
      end else begin
         fclk_pulse <= 1'b0;
         pre_cnt_r <= div_r[DIV_PRESCALE_BIT] ? pre_cnt_r + 3'h1 : 3'h0;
         if (tick) begin
            if (div_cnt_r == div_r[5:0]) begin
               div_cnt_r <= 6'h00;
               fclk_pulse <= 1'b1;
            end else begin
               div_cnt_r <= div_cnt_r + 6'h01;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   property p_load;
      (state_r == ST_OPT && nv_rd_valid)
         |=> opt_r == ($past(nv_rd_data) & OPT_IMPL_MASK);
   endproperty
   a_load: assert property (p_load)
      else $error("option shadow not loaded from option byte");

   property p_rsvd;
      (pend_r && !da_write_r && da_addr_r == OFF_OPT)
         |=> hreadyout && hrdata[5:2] == 4'h0 && hrdata[31:8] == 24'h0;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("option shadow reserved bits not zero");

   property p_ro;
      (opt_wr && !key_unlock && !blank_unlock) |=> $stable(opt_r);
   endproperty
   a_ro: assert property (p_ro)
      else $error("bus write changed option shadow");

   property p_nokey;
      !opt_r[OPT_BACKDOOR_BIT] |-> !key_unlock;
   endproperty
   a_nokey: assert property (p_nokey)
      else $error("key unlock with backdoor disabled");

   property p_unlock;
      (key_unlock || blank_unlock)
         |=> opt_r[1:0] == SEC_UNSECURED ##1 !secure;
   endproperty
   a_unlock: assert property (p_unlock)
      else $error("unlock did not force code 10");

   property p_dbgkey;
      (fl_wr_valid && fl_wr_debug && !key_clear_evt) |=> $stable(key_cnt_r);
   endproperty
   a_dbgkey: assert property (p_dbgkey)
      else $error("debug write fed key comparator");

   // The first edge after release still shows the reset value
   property p_redir;
      $past(resetn) |-> vector_redirect == !$past(opt_r[OPT_NORED_BIT]);
   endproperty
   a_redir: assert property (p_redir)
      else $error("vector redirect wrong");

   property p_sec;
      ##1 secure == ($past(opt_r[1:0]) != 2'b10);
   endproperty
   a_sec: assert property (p_sec)
      else $error("security decode wrong");

   property p_dbg;
      (debug_mem_req && !is_unsecured(opt_r[OPT_SEC_LSB +: 2])
       && !key_unlock && !blank_unlock)
         |=> !debug_mem_grant;
   endproperty
   a_dbg: assert property (p_dbg)
      else $error("debug access granted while secure");

   property p_cfg;
      cfg_wr |=> cfg_r == ($past(hwdata[7:0]) & 8'hE0);
   endproperty
   a_cfg: assert property (p_cfg)
      else $error("config write wrong");

   property p_route;
      (fl_wr_valid && in_key_window(fl_wr_addr))
         |=> cmd_wr_valid == !$past(cfg_r[CFG_KEY_ACCESS_BIT]);
   endproperty
   a_route: assert property (p_route)
      else $error("key window write misrouted");

   property p_inval;
      cfg_r[CFG_KEY_ACCESS_BIT] |=> cpu_rd_data == INVALID_READ;
   endproperty
   a_inval: assert property (p_inval)
      else $error("flash read not invalid under key access");

   property p_fclk;
      (fclk_pulse && div_r[7:6] == 2'b10 && div_r[5:0] == 6'h03)
         |=> !fclk_pulse [*3] ##1 fclk_pulse;
   endproperty
   a_fclk: assert property (p_fclk)
      else $error("flash clock period wrong");

   c_key_unlock: cover property (key_unlock);
   c_blank_unlock: cover property (blank_unlock);
   c_load_done: cover property (state_r == ST_KEY ##1 state_r == ST_RUN);
   c_fwd: cover property (cmd_wr_valid);
endmodule : flash_option_security_config
`default_nettype wire

/* File: tb/flash_option_security_config_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module flash_option_security_config_bench
   import flash_opt_pkg::*;
;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam logic [15:0] NV_ADDR = 16'hFFBF;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic nv_rd_valid = 1'b0;
   logic [7:0] nv_rd_data = 8'h00;
   logic fl_wr_valid = 1'b0;
   logic fl_wr_debug = 1'b0;
   logic [15:0] fl_wr_addr = 16'h0000;
   logic [7:0] fl_wr_data = 8'h00;
   logic [7:0] fl_rd_data = 8'h00;
   logic blank_check_pass = 1'b0;
   logic debug_mem_req = 1'b0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic nv_rd_req;
   logic [15:0] nv_rd_addr;
   logic cmd_wr_valid;
   logic [15:0] cmd_wr_addr;
   logic [7:0] cmd_wr_data;
   logic [7:0] cpu_rd_data;
   logic debug_mem_grant;
   logic secure;
   logic vector_redirect;
   logic fclk_pulse;
   int fail_count = 0;
   int n_tests = 0;

   always #5 clock = ~clock;

   flash_option_security_config #(
      .NV_OPT_ADDR(NV_ADDR)
   ) dut (
      .clock(clock),
      .resetn(resetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hreadyout),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .nv_rd_req(nv_rd_req),
      .nv_rd_addr(nv_rd_addr),
      .nv_rd_data(nv_rd_data),
      .nv_rd_valid(nv_rd_valid),
      .fl_wr_valid(fl_wr_valid),
      .fl_wr_addr(fl_wr_addr),
      .fl_wr_data(fl_wr_data),
      .fl_wr_debug(fl_wr_debug),
      .cmd_wr_valid(cmd_wr_valid),
      .cmd_wr_addr(cmd_wr_addr),
      .cmd_wr_data(cmd_wr_data),
      .fl_rd_data(fl_rd_data),
      .cpu_rd_data(cpu_rd_data),
      .blank_check_pass(blank_check_pass),
      .debug_mem_req(debug_mem_req),
      .debug_mem_grant(debug_mem_grant),
      .secure(secure),
      .vector_redirect(vector_redirect),
      .fclk_pulse(fclk_pulse)
   );

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim

   function automatic logic [7:0] kb(input int i);
      return 8'(8'h3C + 8'h11 * i);
   endfunction : kb

   // Waits on hready with no bound of its own; a stuck bus ends at the
   // watchdog
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      do begin
         @(posedge clock);
      end while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do begin
         @(posedge clock);
      end while (hreadyout !== 1'b1);
      rd = hrdata;
      check(hreadyout, 1);
      check(hresp, 0);
   endtask : bus

   task automatic fw(input logic [15:0] a, input logic [7:0] d,
                     input logic dbg, input logic fwd);
      @(posedge clock);
      fl_wr_valid <= 1'b1;
      fl_wr_addr <= a;
      fl_wr_data <= d;
      fl_wr_debug <= dbg;
      @(posedge clock);
      fl_wr_valid <= 1'b0;
      #1 check(cmd_wr_valid, fwd);
      if (fwd) check({cmd_wr_addr, cmd_wr_data}, {a, d});
   endtask : fw

   // Spaced two cycles apart, ascending through the key window
   task automatic keys(input int n, input logic dbg);
      for (int i = 0; i < n; i++) begin
         fw(KEY_BASE + 16'(i), kb(i), dbg, 1'b0);
      end
   endtask : keys

   task automatic do_reset(input logic [7:0] opt);
      logic [31:0] rd;
      resetn <= 1'b0;
      repeat (10) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      #1 check(secure, 1);
      for (int i = 0; i < 9; i++) begin
         check(nv_rd_addr, (i == 0) ? NV_ADDR : KEY_BASE + 16'(i - 1));
         @(posedge clock);
         nv_rd_valid <= 1'b1;
         nv_rd_data <= (i == 0) ? opt : kb(i - 1);
         @(posedge clock);
         nv_rd_valid <= 1'b0;
         #1;
      end
      check(nv_rd_req, 0);
      bus(1'b0, OFF_OPT, 32'h0000_0000, rd);
      check(rd, {24'h00_0000, opt & 8'hC3});
      bus(1'b1, OFF_OPT, 32'h0000_0002, rd);
      bus(1'b0, OFF_OPT, 32'h0000_0000, rd);
      check(rd, {24'h00_0000, opt & 8'hC3});
      check(secure, opt[1:0] != 2'b10);
      check(vector_redirect, !opt[6]);
   endtask : do_reset

   task automatic div_test(input logic [7:0] v, input int per);
      logic [31:0] rd;
      int n;
      bus(1'b1, OFF_DIV, {24'h00_0000, v}, rd);
      bus(1'b1, OFF_DIV, 32'h0000_0015, rd);
      bus(1'b0, OFF_DIV, 32'h0000_0000, rd);
      check(rd, {24'h00_0000, 1'b1, v[6:0]});
      n = 0;
      while (fclk_pulse !== 1'b1 && n < 2000) begin
         @(posedge clock);
         n++;
      end
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (fclk_pulse !== 1'b1 && n < 2000);
      check(n, per);
      // Only the slow setting meets the pulse window; short ones keep
      // the run brief
      if (per >= PULSE_MIN_CYC) begin
         check(n >= PULSE_MIN_CYC && n <= PULSE_MAX_CYC, 1);
      end
   endtask : div_test

   task automatic cfg(input logic [31:0] d);
      logic [31:0] rd;
      bus(1'b1, OFF_CFG, d, rd);
   endtask : cfg

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic sc_unlock;
      logic [31:0] rd;
      do_reset(8'hBD);
      @(posedge clock);
      debug_mem_req <= 1'b1;
      fl_rd_data <= 8'h5A;
      repeat (2) @(posedge clock);
      #1 check(debug_mem_grant, 0);
      check(cpu_rd_data, 8'h5A);
      cfg(32'h0000_00FF);
      bus(1'b0, OFF_CFG, 32'h0000_0000, rd);
      check(rd, 32'h0000_00E0);
      check(cpu_rd_data, 8'hFF);
      keys(8, 1'b1);
      cfg(32'h0000_0000);
      repeat (2) @(posedge clock);
      #1 check(secure, 1);
      cfg(32'h0000_0020);
      keys(8, 1'b0);
      cfg(32'h0000_0000);
      repeat (2) @(posedge clock);
      #1 check(secure, 0);
      check(debug_mem_grant, 1);
      bus(1'b0, OFF_OPT, 32'h0000_0000, rd);
      check(rd, 32'h0000_0082);
      debug_mem_req <= 1'b0;
      div_test(8'h03, 4);
   endtask : sc_unlock

   task automatic sc_locked;
      do_reset(8'h7F);
      cfg(32'h0000_0020);
      keys(8, 1'b0);
      cfg(32'h0000_0000);
      repeat (2) @(posedge clock);
      #1 check(secure, 1);
      div_test(8'h41, 16);
      // Seven bytes only, then a blank check
      do_reset(8'h80);
      cfg(32'h0000_0020);
      keys(7, 1'b0);
      cfg(32'h0000_0000);
      repeat (2) @(posedge clock);
      #1 check(secure, 1);
      @(posedge clock);
      blank_check_pass <= 1'b1;
      @(posedge clock);
      blank_check_pass <= 1'b0;
      repeat (2) @(posedge clock);
      #1 check(secure, 0);
      div_test(8'h7E, 504);
   endtask : sc_locked

   task automatic sc_plain;
      logic [31:0] rd;
      do_reset(8'hC2);
      fw(16'hFFB3, 8'h77, 1'b0, 1'b1);
      fw(16'h1234, 8'h99, 1'b0, 1'b1);
      bus(1'b0, 8'h0C, 32'h0000_0000, rd);
      check(rd, 32'h0000_0000);
      check(hresp, 0);
      div_test(8'h00, 1);
   endtask : sc_plain

   initial begin
      sc_unlock();
      sc_locked();
      sc_plain();
      end_sim();
   end

   initial begin
      #500000;
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_sim();
   end
endmodule : flash_option_security_config_bench
`default_nettype wire
